// *** pcc_clock_control.sv ***
// clock controller: pll relock, source switch-over, lock status, peripheral gating, sleep modes
`timescale 1ns/1ps
`include "pcc_defs.svh"

module pcc_clock_control #(
  parameter logic [12:0] RELOCK_COUNT = `PCC_RELOCK_COUNT
) (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire pcc_pkg::pcc_word_t PWDATA_IN,
  output pcc_pkg::pcc_word_t PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic MOSC_TICK_IN,
  input wire logic OSC_TICK_IN,
  input wire logic PLL_TICK_IN,
  input wire logic WAIT_FOR_INTERRUPT_IN,
  input wire logic DEEP_SLEEP_ENABLE_IN,
  input wire logic WAKE_EVENT_IN,
  output pcc_pkg::pcc_mode_e POWER_MODE_OUT,
  output logic CPU_CLK_EN_OUT,
  output logic MEM_CLK_EN_OUT,
  output logic [95:0] PERIPH_CLK_EN_OUT,
  output logic SYSCLK_USE_PLL_OUT,
  output logic [2:0] SYSCLK_OSC_SEL_OUT,
  output logic SYSCLK_TICK_OUT,
  output logic PLL_POWER_DOWN_OUT,
  output logic MOSC_POWER_DOWN_OUT,
  output logic INT_OSC_POWER_UP_OUT,
  output logic PLL_LOCK_IRQ_OUT
);
  import pcc_pkg::*;

  pcc_word_t clock_config_primary_reg;
  pcc_word_t clock_config_secondary_reg;
  pcc_word_t deep_sleep_clock_config_reg;
  pcc_word_t pll_config_reg;
  pcc_word_t gate_reg [3*`PCC_GATE_REGS];
  pcc_word_t prdata_reg;
  logic err_reg;
  logic lock_mask_reg;
  logic pll_lock_raw_flag_reg;
  logic pll_pd_prev_reg;
  logic deep_force_pd_reg;
  logic saved_use_pll_reg;
  pcc_mode_e mode_reg;
  pcc_mode_e mode_next;
  logic cpu_en_reg;
  logic [95:0] periph_reg;
  logic [95:0] periph_next;

  logic setup, wr_access;
  logic wr_primary, relock_trig, relock_expired, relock_done;
  logic second_config_enable, auto_gating, eff_bypass, eff_pd, pll_pd_act, pll_ready;
  logic use_pll, divider_use, in_deep;
  logic [2:0] eff_osc, dslp_osc;
  logic [5:0] eff_div, dslp_div, div_value;
  logic [4:0] crystal_select;

  // effective settings, secondary register taking over when enabled
  assign second_config_enable = clock_config_secondary_reg[`PCC_SEC_USE];
  assign eff_bypass = second_config_enable ? clock_config_secondary_reg[`PCC_SEC_BYPASS]
                                           : clock_config_primary_reg[`PCC_PRI_BYPASS];
  assign eff_pd = second_config_enable ? clock_config_secondary_reg[`PCC_SEC_PD]
                                       : clock_config_primary_reg[`PCC_PRI_PD];
  assign eff_osc = second_config_enable ?
                   clock_config_secondary_reg[`PCC_SEC_OSC_HI:`PCC_SEC_OSC_LO]
                   : {1'b0, clock_config_primary_reg[`PCC_PRI_OSC_HI:`PCC_PRI_OSC_LO]};
  assign eff_div = second_config_enable ?
                   clock_config_secondary_reg[`PCC_SEC_DIV_HI:`PCC_SEC_DIV_LO]
                   : {2'b00, clock_config_primary_reg[`PCC_PRI_DIV_HI:`PCC_PRI_DIV_LO]};
  assign crystal_select = clock_config_primary_reg[`PCC_PRI_CRYSTAL_HI:`PCC_PRI_CRYSTAL_LO];
  assign auto_gating = clock_config_primary_reg[`PCC_PRI_ACG];
  assign dslp_osc = deep_sleep_clock_config_reg[`PCC_DSLP_OSC_HI:`PCC_DSLP_OSC_LO];
  // primary register only reaches /16, so its override is cut to four bits
  assign dslp_div = second_config_enable ?
                    deep_sleep_clock_config_reg[`PCC_DSLP_DIV_HI:`PCC_DSLP_DIV_LO]
                    : {2'b00, deep_sleep_clock_config_reg[`PCC_DSLP_DIV_LO+3:`PCC_DSLP_DIV_LO]};
  assign in_deep = (mode_reg == PCC_DEEP);

  // apb slave: zero-wait access, read data captured in the setup cycle
  assign setup = PSEL_IN && !PENABLE_IN;
  assign wr_access = PSEL_IN && PENABLE_IN && PWRITE_IN && !err_reg;
  assign wr_primary = wr_access && PADDR_IN == `PCC_OFF_CFG_PRI;
  assign PREADY_OUT = PSEL_IN && PENABLE_IN;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && err_reg;
  assign PRDATA_OUT = prdata_reg;

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
    begin
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end
    else if (setup)
    begin
      err_reg <= 1'b0;
      unique case (PADDR_IN)
        `PCC_OFF_RAW_IRQ: prdata_reg <= {25'h000_0000, pll_lock_raw_flag_reg, 6'h00};
        `PCC_OFF_IMC: prdata_reg <= {25'h000_0000, lock_mask_reg, 6'h00};
        `PCC_OFF_MISC: prdata_reg <= {25'h000_0000, pll_lock_raw_flag_reg && lock_mask_reg, 6'h00};
        `PCC_OFF_CFG_PRI: prdata_reg <= clock_config_primary_reg;
        `PCC_OFF_PLLCFG: prdata_reg <= pll_config_reg;
        `PCC_OFF_CFG_SEC: prdata_reg <= clock_config_secondary_reg;
        `PCC_OFF_DSLP_CFG: prdata_reg <= deep_sleep_clock_config_reg;
        `PCC_OFF_RUN_GATE, `PCC_OFF_RUN_GATE + 12'h004, `PCC_OFF_RUN_GATE + 12'h008:
          prdata_reg <= gate_reg[PADDR_IN[3:2]];
        `PCC_OFF_SLEEP_GATE, `PCC_OFF_SLEEP_GATE + 12'h004, `PCC_OFF_SLEEP_GATE + 12'h008:
          prdata_reg <= gate_reg[3 + PADDR_IN[3:2]];
        `PCC_OFF_DEEP_GATE, `PCC_OFF_DEEP_GATE + 12'h004, `PCC_OFF_DEEP_GATE + 12'h008:
          prdata_reg <= gate_reg[6 + PADDR_IN[3:2]];
        default:
        begin
          prdata_reg <= 32'h0000_0000;
          err_reg <= 1'b1;
        end
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
    begin
      clock_config_primary_reg <= `PCC_RST_CFG_PRI;
      clock_config_secondary_reg <= `PCC_RST_CFG_SEC;
      deep_sleep_clock_config_reg <= `PCC_RST_DSLP;
      lock_mask_reg <= 1'b0;
    end
    else if (wr_access)
    begin
      if (PADDR_IN == `PCC_OFF_CFG_PRI)
        clock_config_primary_reg <= PWDATA_IN;
      if (PADDR_IN == `PCC_OFF_CFG_SEC)
        clock_config_secondary_reg <= PWDATA_IN;
      if (PADDR_IN == `PCC_OFF_DSLP_CFG)
        deep_sleep_clock_config_reg <= PWDATA_IN;
      if (PADDR_IN == `PCC_OFF_IMC)
        lock_mask_reg <= PWDATA_IN[`PCC_LOCK_BIT];
    end
  end

  // gating registers, one per entry; word 0 of each bank resets with its default bit
  for (genvar g = 0; g < 3 * `PCC_GATE_REGS; g++)
  begin : gen_gate
    localparam logic [11:0] GATE_OFF = `PCC_OFF_RUN_GATE + 12'(16 * (g / 3) + 4 * (g % 3));
    always_ff @(posedge SYS_CLK_IN)
    begin
      if (RESET_IN)
        gate_reg[g] <= (g % 3 == 0) ? `PCC_RST_GATE0 : `PCC_RST_GATE;
      else if (wr_access && PADDR_IN == GATE_OFF)
        gate_reg[g] <= PWDATA_IN;
    end
  end

  // crystal write loads the translated pll setting; the index is what the pll decodes
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      pll_config_reg <= `PCC_RST_PLL_CFG;
    else if (wr_primary)
      pll_config_reg <= {27'h000_0000, PWDATA_IN[`PCC_PRI_CRYSTAL_HI:`PCC_PRI_CRYSTAL_LO]};
  end

  // pll power: software bit, plus forced off while in deep sleep
  assign pll_pd_act = eff_pd || deep_force_pd_reg;
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      pll_pd_prev_reg <= 1'b1;
    else
      pll_pd_prev_reg <= pll_pd_act;
  end

  // only a changed crystal or a power-up counts; a same-value rewrite is ignored
  assign relock_trig = (wr_primary && PWDATA_IN[`PCC_PRI_CRYSTAL_HI:`PCC_PRI_CRYSTAL_LO] != crystal_select)
                       || (pll_pd_prev_reg && !pll_pd_act);

  pcc_relock_counter #(
    .RELOCK_COUNT(RELOCK_COUNT)
  ) u_relock (
    .clk_in(SYS_CLK_IN),
    .rst_in(RESET_IN),
    .load_in(relock_trig),
    .osc_tick_in(MOSC_TICK_IN),
    .expired_out(relock_expired),
    .done_out(relock_done)
  );

  // a new relock beats a completing one: the old lock no longer describes the pll
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      pll_lock_raw_flag_reg <= 1'b0;
    else if (relock_trig)
      pll_lock_raw_flag_reg <= 1'b0;
    else if (relock_done)
      pll_lock_raw_flag_reg <= 1'b1;
    else if (wr_access && PADDR_IN == `PCC_OFF_MISC && PWDATA_IN[`PCC_LOCK_BIT])
      pll_lock_raw_flag_reg <= 1'b0;
  end
  assign PLL_LOCK_IRQ_OUT = pll_lock_raw_flag_reg && lock_mask_reg;

  // oscillator serves until the pll is powered and relocked
  assign pll_ready = relock_expired && !pll_pd_act && !relock_trig;
  assign use_pll = !eff_bypass && pll_ready && !in_deep;
  assign divider_use = clock_config_primary_reg[`PCC_PRI_DIV_USE] || in_deep;
  assign div_value = in_deep && saved_use_pll_reg ? dslp_div : eff_div;
  assign SYSCLK_USE_PLL_OUT = use_pll;
  assign SYSCLK_OSC_SEL_OUT = in_deep ? dslp_osc : eff_osc;
  assign PLL_POWER_DOWN_OUT = pll_pd_act;
  assign MOSC_POWER_DOWN_OUT = in_deep && dslp_osc != `PCC_OSC_MAIN;
  assign INT_OSC_POWER_UP_OUT = in_deep && (dslp_osc == `PCC_OSC_INT || dslp_osc == `PCC_OSC_INT4);

  pcc_sysclk_divider u_div (
    .clk_in(SYS_CLK_IN),
    .rst_in(RESET_IN),
    .src_tick_in(use_pll ? PLL_TICK_IN : OSC_TICK_IN),
    .prediv_in(use_pll),
    .div_en_in(divider_use),
    .div_value_in(div_value),
    .tick_out(SYSCLK_TICK_OUT)
  );

  // power mode sequencing; restore waits for the relocked pll, if it was in use at deep entry, before clocks return
  always_comb
  begin
    mode_next = mode_reg;
    unique case (mode_reg)
      PCC_RUN:
        if (WAIT_FOR_INTERRUPT_IN)
          mode_next = DEEP_SLEEP_ENABLE_IN ? PCC_DEEP : PCC_SLEEP;
      PCC_SLEEP:
        if (WAKE_EVENT_IN)
          mode_next = PCC_RUN;
      PCC_DEEP:
        if (WAKE_EVENT_IN)
          mode_next = PCC_RESTORE;
      PCC_RESTORE:
        if (!saved_use_pll_reg || pll_ready)
          mode_next = PCC_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
      mode_reg <= PCC_RUN;
    else
      mode_reg <= mode_next;
  end

  // deep entry remembers whether the pll ran, and holds it down until the wake event
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
    begin
      deep_force_pd_reg <= 1'b0;
      saved_use_pll_reg <= 1'b0;
    end
    else if (mode_reg == PCC_RUN && mode_next == PCC_DEEP)
    begin
      deep_force_pd_reg <= !pll_pd_act;
      saved_use_pll_reg <= use_pll;
    end
    else if (mode_reg == PCC_DEEP && mode_next == PCC_RESTORE)
      deep_force_pd_reg <= 1'b0;
  end

  // peripheral gating per mode; sleep leaves source and divider untouched
  always_comb
  begin
    periph_next = {gate_reg[2], gate_reg[1], gate_reg[0]};
    if (mode_next == PCC_SLEEP && auto_gating)
      periph_next = {gate_reg[5], gate_reg[4], gate_reg[3]};
    else if ((mode_next == PCC_DEEP || mode_next == PCC_RESTORE) && auto_gating)
      periph_next = {gate_reg[8], gate_reg[7], gate_reg[6]};
  end

  // outputs registered so gating changes are glitch free at the gate cells
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
    begin
      cpu_en_reg <= 1'b1;
      periph_reg <= {`PCC_RST_GATE, `PCC_RST_GATE, `PCC_RST_GATE0};
    end
    else
    begin
      cpu_en_reg <= (mode_next == PCC_RUN);
      periph_reg <= periph_next;
    end
  end

  assign POWER_MODE_OUT = mode_reg;
  assign CPU_CLK_EN_OUT = cpu_en_reg;
  assign MEM_CLK_EN_OUT = cpu_en_reg;
  assign PERIPH_CLK_EN_OUT = periph_reg;

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  a_relock_on_crystal: assert property (wr_primary && PWDATA_IN[10:6] != crystal_select
    |=> !relock_expired && !pll_lock_raw_flag_reg) else $error("crystal change did not start relock");
  a_same_crystal_quiet: assert property (wr_primary && PWDATA_IN[10:6] == crystal_select &&
    !pll_pd_prev_reg && relock_expired |=> relock_expired) else $error("same crystal restarted relock");
  a_pll_blocked: assert property (SYSCLK_USE_PLL_OUT |-> relock_expired && !PLL_POWER_DOWN_OUT)
    else $error("pll selected before relock expired");
  a_lock_flag_set: assert property (relock_done && !relock_trig |=> pll_lock_raw_flag_reg)
    else $error("lock flag not set after relock");
  a_lock_cleared: assert property (relock_trig |=> !pll_lock_raw_flag_reg)
    else $error("relock trigger left lock flag set");
  a_sleep_cpu_off: assert property (mode_reg != PCC_RUN |-> !CPU_CLK_EN_OUT && !MEM_CLK_EN_OUT)
    else $error("processor clocked outside run");
  a_sleep_gating: assert property (mode_reg == PCC_SLEEP && $past(mode_reg) == PCC_SLEEP &&
    $stable(auto_gating) |-> PERIPH_CLK_EN_OUT == ($past(auto_gating) ?
    $past({gate_reg[5], gate_reg[4], gate_reg[3]}) : $past({gate_reg[2], gate_reg[1], gate_reg[0]})))
    else $error("sleep gating wrong");
  a_deep_pll_off: assert property (mode_reg == PCC_DEEP && saved_use_pll_reg
    |-> PLL_POWER_DOWN_OUT && div_value == dslp_div) else $error("pll not overridden in deep sleep");
  a_wake_sleep: assert property (mode_reg == PCC_SLEEP && WAKE_EVENT_IN |=> mode_reg == PCC_RUN
    && CPU_CLK_EN_OUT) else $error("sleep wake not honoured");
  a_restore_order: assert property (mode_reg == PCC_RESTORE && saved_use_pll_reg && !pll_ready
    |=> mode_reg == PCC_RESTORE && !CPU_CLK_EN_OUT) else $error("clocks restored before pll relock");
  a_second_config: assert property (second_config_enable && !in_deep
    |-> div_value == clock_config_secondary_reg[28:23]) else $error("secondary divider not used");

endmodule : pcc_clock_control

// *** pcc_defs.svh ***
// register offsets, field positions, reset values and timing counts of the clock controller
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH

// register byte offsets
`define PCC_OFF_RAW_IRQ 12'h050
`define PCC_OFF_IMC 12'h054
`define PCC_OFF_MISC 12'h058
`define PCC_OFF_CFG_PRI 12'h060
`define PCC_OFF_PLLCFG 12'h064
`define PCC_OFF_CFG_SEC 12'h070
`define PCC_OFF_RUN_GATE 12'h100
`define PCC_OFF_SLEEP_GATE 12'h110
`define PCC_OFF_DEEP_GATE 12'h120
`define PCC_OFF_DSLP_CFG 12'h144
`define PCC_GATE_REGS 3

// reset values
`define PCC_RST_CFG_PRI 32'h0780_3AD1
`define PCC_RST_CFG_SEC 32'h0780_2810
`define PCC_RST_DSLP 32'h0780_0000
// crystal index held in the primary reset value, as the translation register shows it
`define PCC_RST_PLL_CFG 32'h0000_000B
`define PCC_RST_GATE0 32'h0000_0040
`define PCC_RST_GATE 32'h0000_0000

// primary configuration fields
`define PCC_PRI_OSC_LO 4
`define PCC_PRI_OSC_HI 5
`define PCC_PRI_CRYSTAL_LO 6
`define PCC_PRI_CRYSTAL_HI 10
`define PCC_PRI_BYPASS 11
`define PCC_PRI_PD 13
`define PCC_PRI_DIV_USE 22
`define PCC_PRI_DIV_LO 23
`define PCC_PRI_DIV_HI 26
`define PCC_PRI_ACG 27

// secondary configuration fields
`define PCC_SEC_OSC_LO 4
`define PCC_SEC_OSC_HI 6
`define PCC_SEC_BYPASS 11
`define PCC_SEC_PD 13
`define PCC_SEC_DIV_LO 23
`define PCC_SEC_DIV_HI 28
`define PCC_SEC_USE 31

// deep-sleep clock configuration fields
`define PCC_DSLP_OSC_LO 4
`define PCC_DSLP_OSC_HI 6
`define PCC_DSLP_DIV_LO 23
`define PCC_DSLP_DIV_HI 28

// status bit and oscillator codes
`define PCC_LOCK_BIT 6
`define PCC_OSC_MAIN 3'h0
`define PCC_OSC_INT 3'h1
`define PCC_OSC_INT4 3'h2

// relock period in main-oscillator ticks
`define PCC_RELOCK_COUNT 13'h1200

`endif

// *** pcc_pkg.sv ***
// types shared by the clock controller modules
package pcc_pkg;

  typedef enum logic [1:0] {PCC_RUN, PCC_SLEEP, PCC_DEEP, PCC_RESTORE} pcc_mode_e;
  typedef logic [31:0] pcc_word_t;

endpackage : pcc_pkg

// *** pcc_relock_counter.sv ***
// relock down counter stepped by main-oscillator ticks
`timescale 1ns/1ps
`include "pcc_defs.svh"

module pcc_relock_counter #(
  parameter logic [12:0] RELOCK_COUNT = `PCC_RELOCK_COUNT
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic osc_tick_in,
  output logic expired_out,
  output logic done_out
);
  import pcc_pkg::*;

  logic [12:0] count_reg;
  logic done_reg;

  // a load always wins, so a relock during a count restarts it
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      count_reg <= 13'h0000;
    else if (load_in)
      count_reg <= RELOCK_COUNT;
    else if (osc_tick_in && count_reg != 13'h0000)
      count_reg <= count_reg - 13'h0001;
  end

  // one-cycle pulse on the final tick of a count
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      done_reg <= 1'b0;
    else
      done_reg <= osc_tick_in && !load_in && count_reg == 13'h0001;
  end

  assign expired_out = (count_reg == 13'h0000);
  assign done_out = done_reg;

endmodule : pcc_relock_counter

// *** pcc_sysclk_divider.sv ***
// system clock divider producing one tick per divided period
`timescale 1ns/1ps

module pcc_sysclk_divider (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic src_tick_in,
  input wire logic prediv_in,
  input wire logic div_en_in,
  input wire logic [5:0] div_value_in,
  output logic tick_out
);
  import pcc_pkg::*;

  logic half_reg;
  logic [5:0] count_reg;
  logic tick_reg;
  logic stage_tick;

  // fixed halving of the pll output ahead of the divider
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      half_reg <= 1'b0;
    else if (prediv_in && src_tick_in)
      half_reg <= !half_reg;
  end

  assign stage_tick = prediv_in ? (src_tick_in && half_reg) : src_tick_in;

  // count value+1 stage ticks per output tick
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      count_reg <= 6'h00;
    else if (stage_tick)
      count_reg <= (count_reg >= div_value_in) ? 6'h00 : count_reg + 6'h01;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      tick_reg <= 1'b0;
    else
      tick_reg <= stage_tick && (!div_en_in || count_reg >= div_value_in);
  end

  assign tick_out = tick_reg;

endmodule : pcc_sysclk_divider

// *** test_pcc_clock_control.sv ***
// self-checking bench for the clock controller
`timescale 1ns/1ps
`include "pcc_defs.svh"
`define CHK(n, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("unexpected %s: expected %h, seen %h", n, e, g); \
    end \
  end

module test_pcc_clock_control;
  import pcc_pkg::*;
  // short relock keeps the run brief; two bench cycles per main-oscillator tick
  localparam logic [12:0] RELOCK = 13'h0010;
  localparam int LOCK_CYC = 32;
  localparam pcc_word_t CFG_PLL = 32'h07C0_12D1; // pll powered and selected in one write
  localparam pcc_word_t CFG_CRYSTAL = 32'h07C0_1311; // crystal index moved to 0xc
  localparam pcc_word_t CFG_ACG = 32'h0FC0_1311; // same plus automatic gating
  localparam logic [11:0] RA [8] = '{`PCC_OFF_CFG_PRI, `PCC_OFF_CFG_SEC, `PCC_OFF_DSLP_CFG, 12'h100, 12'h104,
    12'h110, 12'h120, `PCC_OFF_RAW_IRQ};
  localparam pcc_word_t RV [8] = '{`PCC_RST_CFG_PRI, `PCC_RST_CFG_SEC, `PCC_RST_DSLP, 32'h0000_0040,
    32'h0000_0000, 32'h0000_0040, 32'h0000_0040, 32'h0000_0000};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  pcc_word_t pwd = 32'h0000_0000;
  logic mosc = 1'b0;
  logic osc = 1'b0;
  logic pll = 1'b0;
  logic sleep_req = 1'b0;
  logic dse = 1'b0;
  logic wake = 1'b0;
  logic [1:0] tcnt = 2'h0;
  pcc_word_t prd;
  logic rdy, err, cpu, mem, upll, stick, ppd, mpd, iup, irq;
  logic [95:0] per;
  logic [2:0] osel;
  pcc_mode_e mode;
  int mismatches = 0;
  int compares = 0;

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  // oscillator ticks: main every 2nd cycle, selected one every 3rd, pll vco every cycle
  always @(posedge clk)
  begin
    tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
    mosc <= ~mosc;
    osc <= (tcnt == 2'h0);
    pll <= ~rst;
  end

  pcc_clock_control #(.RELOCK_COUNT(RELOCK)) u_pcc_clock_control (
    .SYS_CLK_IN(clk),
    .RESET_IN(rst),
    .PSEL_IN(psel),
    .PENABLE_IN(pen),
    .PWRITE_IN(pwr),
    .PADDR_IN(padr),
    .PWDATA_IN(pwd),
    .PRDATA_OUT(prd),
    .PREADY_OUT(rdy),
    .PSLVERR_OUT(err),
    .MOSC_TICK_IN(mosc),
    .OSC_TICK_IN(osc),
    .PLL_TICK_IN(pll),
    .WAIT_FOR_INTERRUPT_IN(sleep_req),
    .DEEP_SLEEP_ENABLE_IN(dse),
    .WAKE_EVENT_IN(wake),
    .POWER_MODE_OUT(mode),
    .CPU_CLK_EN_OUT(cpu),
    .MEM_CLK_EN_OUT(mem),
    .PERIPH_CLK_EN_OUT(per),
    .SYSCLK_USE_PLL_OUT(upll),
    .SYSCLK_OSC_SEL_OUT(osel),
    .SYSCLK_TICK_OUT(stick),
    .PLL_POWER_DOWN_OUT(ppd),
    .MOSC_POWER_DOWN_OUT(mpd),
    .INT_OSC_POWER_UP_OUT(iup),
    .PLL_LOCK_IRQ_OUT(irq)
  );

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic time_out();
    mismatches++;
    give_verdict();
  endtask : time_out

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input pcc_word_t d, output pcc_word_t r,
    output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (rdy === 1'b1)
        break;
    end
    r = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n == 20)
      time_out();
  endtask : apb

  task automatic wr(input logic [11:0] a, input pcc_word_t d);
    pcc_word_t r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input pcc_word_t x, input logic xe);
    pcc_word_t r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK("read data", x, r)
    `CHK("slave error", xe, e)
  endtask : rd

  task automatic nap(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : nap

  // one-cycle core request; d picks deep sleep
  task automatic slp(input logic d);
    @(posedge clk);
    sleep_req <= 1'b1;
    dse <= d;
    @(posedge clk);
    sleep_req <= 1'b0;
    @(negedge clk);
  endtask : slp

  task automatic wk();
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    @(negedge clk);
  endtask : wk

  // spacing in cycles between two divided system-clock ticks
  task automatic period(input int x);
    int n;
    int k;
    for (n = 0; n < 100 && stick !== 1'b1; n++)
      @(negedge clk);
    for (k = 1; k < 100; k++)
    begin
      @(negedge clk);
      if (stick === 1'b1)
        break;
    end
    `CHK("tick period", x, k)
  endtask : period

  // wait is bounded so a lock that never comes ends the run
  task automatic wait_irq();
    int n;
    for (n = 0; n < 100 && irq !== 1'b1; n++)
      @(negedge clk);
    if (n == 100)
      time_out();
  endtask : wait_irq

  function automatic pcc_word_t gv(input int b, input int i);
    return pcc_word_t'(b * 16 + i + 1);
  endfunction : gv

  function automatic logic [95:0] bank(input int b);
    return {gv(b, 2), gv(b, 1), gv(b, 0)};
  endfunction : bank

  // main sequence
  initial
  begin
    int n;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("cpu clock", 1'b1, cpu)
    `CHK("periph reset", 96'h0000_0040, per)
    `CHK("pll off", 1'b1, ppd)
    for (n = 0; n < 8; n++)
      rd(RA[n], RV[n], 1'b0);
    rd(12'h200, 32'h0000_0000, 1'b1);
    wr(`PCC_OFF_RAW_IRQ, 32'hFFFF_FFFF);
    rd(`PCC_OFF_RAW_IRQ, 32'h0000_0000, 1'b0);
    wr(`PCC_OFF_IMC, 32'h0000_0040);
    // the main and selected bench oscillators run from time zero, so a stable source exists before this write
    wr(`PCC_OFF_CFG_PRI, CFG_PLL);
    nap(LOCK_CYC - 4);
    `CHK("early lock", 1'b0, irq)
    `CHK("early pll use", 1'b0, upll)
    `CHK("pll powered", 1'b0, ppd)
    nap(8);
    `CHK("lock irq", 1'b1, irq)
    rd(`PCC_OFF_RAW_IRQ, 32'h0000_0040, 1'b0);
    `CHK("pll in use", 1'b1, upll)
    period(32);
    wr(`PCC_OFF_CFG_PRI, CFG_PLL);
    nap(1);
    `CHK("lock kept", 1'b1, irq)
    wr(`PCC_OFF_CFG_PRI, CFG_CRYSTAL);
    nap(1);
    `CHK("lock cleared", 1'b0, irq)
    `CHK("pll blocked", 1'b0, upll)
    rd(`PCC_OFF_PLLCFG, 32'h0000_000C, 1'b0);
    wait_irq();
    rd(`PCC_OFF_MISC, 32'h0000_0040, 1'b0);
    for (n = 0; n < 9; n++)
      wr(12'h100 + 12'(16 * (n / 3) + 4 * (n % 3)), gv(n / 3, n % 3));
    nap(1);
    `CHK("run gating", bank(0), per)
    slp(1'b0);
    `CHK("sleep mode", PCC_SLEEP, mode)
    `CHK("sleep cpu", 1'b0, cpu)
    `CHK("sleep mem", 1'b0, mem)
    `CHK("sleep gating", bank(0), per)
    `CHK("sleep source", 1'b1, upll)
    period(32);
    wk();
    `CHK("woken", PCC_RUN, mode)
    wr(`PCC_OFF_CFG_PRI, CFG_ACG);
    slp(1'b0);
    `CHK("auto gating", bank(1), per)
    wk();
    wr(`PCC_OFF_DSLP_CFG, 32'h0180_0010);
    slp(1'b1);
    `CHK("deep mode", PCC_DEEP, mode)
    `CHK("deep cpu", 1'b0, cpu)
    `CHK("deep gating", bank(2), per)
    `CHK("deep pll off", 1'b1, ppd)
    `CHK("main osc off", 1'b1, mpd)
    `CHK("int osc on", 1'b1, iup)
    `CHK("deep source", 3'h1, osel)
    period(12);
    wk();
    `CHK("restoring", PCC_RESTORE, mode)
    `CHK("cpu held", 1'b0, cpu)
    for (n = 0; n < 200 && mode !== PCC_RUN; n++)
      @(negedge clk);
    if (n == 200)
      time_out();
    `CHK("source back", 1'b1, upll)
    nap(1);
    `CHK("cpu back", 1'b1, cpu)
    `CHK("run gating back", bank(0), per)
    wr(`PCC_OFF_MISC, 32'h0000_0040);
    nap(1);
    `CHK("irq cleared", 1'b0, irq)
    // five-step pll change: bypass, crystal, divider, poll lock, release bypass
    wr(`PCC_OFF_CFG_PRI, 32'h0F80_1B11);
    nap(1);
    `CHK("step1 bypass", 1'b0, upll)
    wr(`PCC_OFF_CFG_PRI, 32'h0F80_1AD1);
    wr(`PCC_OFF_CFG_PRI, 32'h0BC0_1AD1);
    wait_irq();
    rd(`PCC_OFF_RAW_IRQ, 32'h0000_0040, 1'b0);
    `CHK("bypass held", 1'b0, upll)
    wr(`PCC_OFF_CFG_PRI, 32'h0BC0_12D1);
    nap(1);
    `CHK("step5 pll", 1'b1, upll)
    period(16);
    wr(`PCC_OFF_CFG_SEC, 32'h8780_2810);
    nap(1);
    `CHK("second config pll", 1'b1, ppd)
    `CHK("second config use", 1'b0, upll)
    give_verdict();
  end

endmodule : test_pcc_clock_control
